// ### ixo_exec.sv
// Module: four-phase executor of the indexed-offset instructions
`timescale 1ns/1ns
// What this block does
// - Add-indexed adds the working register to memory at pointer plus offset 0..95 and updates N, OV, C, DC, Z.
// - Add-indexed stores the sum in the working register when d is 0 and back to memory when d is 1.
// - Add-indexed is recognised as 0010 01d0 kkkk kkkk.
// - Bit-set-indexed 1000 bbb0 kkkk kkkk sets bit b of memory at pointer plus offset, flags untouched.
// - Fill-indexed 0110 1000 kkkk kkkk writes all ones to pointer plus offset, flags untouched.
module ixo_exec (
    // Clock and reset
    input  wire logic                     CLK,
    input  wire logic                     RESET,
    input  wire logic                     CE,
    // Instruction from fetch
    input  wire logic [15:0]              INSTR,
    input  wire logic                     INSTR_VALID,
    input  wire logic [ixo_pkg::ADDR_W-1:0] POINTER_TWO_REG,
    // Data memory
    output logic [ixo_pkg::ADDR_W-1:0]    MEM_ADDR,
    output logic                          MEM_RD,
    input  wire logic [7:0]               MEM_RDATA,
    output logic                          MEM_WR,
    output logic [7:0]                    MEM_WDATA,
    // Core state
    output logic [7:0]                    WORK,
    output logic [4:0]                    FLAGS,
    output logic [1:0]                    PHASE,
    output logic                          DONE,
    output logic                          ILLEGAL
);
    import ixo_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        ixo_phase_e          phase;
        ixo_op_e             op;
        logic                dest_mem;
        logic [2:0]          bit_idx;
        logic [ADDR_W-1:0]   addr;
        logic [7:0]          operand;
        logic [7:0]          result;
        logic [4:0]          flags;
        logic [7:0]          work;
        logic                mem_rd;
        logic                mem_wr;
        logic [7:0]          wdata;
        logic                done;
        logic                illegal;
    } ixo_state_s;

    ixo_state_s st, next_st;
    ixo_dec_if  dif ();

    assign dif.instr = INSTR;
    ixo_decoder u_dec (
        .d (dif)
    );

    logic [8:0] sum;
    logic [4:0] sum_lo;

    always_comb begin
        next_st = st;
        next_st.mem_rd = 1'b0;
        next_st.mem_wr = 1'b0;
        next_st.done   = 1'b0;
        sum    = {1'b0, st.work} + {1'b0, st.operand};
        sum_lo = {1'b0, st.work[3:0]} + {1'b0, st.operand[3:0]};
        // Four phases per instruction cycle
        case (st.phase)
            IXO_DECODE: begin
                if (INSTR_VALID) begin
                    next_st.op       = dif.op;
                    next_st.dest_mem = dif.dest_mem;
                    next_st.bit_idx  = dif.bit_idx;
                    // Offset beyond 95 is refused, slot passes as a no-op
                    next_st.illegal  = (dif.op != IXO_OP_NONE) && !dif.ofs_ok;
                    if (!dif.ofs_ok) begin
                        next_st.op = IXO_OP_NONE;
                    end
                    next_st.addr = POINTER_TWO_REG +
                        {{(ADDR_W-8){1'b0}}, dif.offset};
                end else begin
                    next_st.op      = IXO_OP_NONE;
                    next_st.illegal = 1'b0;
                end
                next_st.phase = IXO_READ;
            end
            IXO_READ: begin
                // Read issued here, data sampled in process phase
                next_st.mem_rd = (st.op == IXO_OP_ADD) ||
                                 (st.op == IXO_OP_BSET);
                next_st.phase  = IXO_PROCESS;
            end
            IXO_PROCESS: begin
                next_st.operand = MEM_RDATA;
                next_st.phase   = IXO_WRITE;
            end
            IXO_WRITE: begin
                case (st.op)
                    IXO_OP_ADD: begin
                        next_st.flags[FL_C]  = sum[8];
                        next_st.flags[FL_DC] = sum_lo[4];
                        next_st.flags[FL_Z]  = (sum[7:0] == 8'h00);
                        next_st.flags[FL_N]  = sum[7];
                        next_st.flags[FL_OV] =
                            (st.work[7] == st.operand[7]) &&
                            (sum[7] != st.work[7]);
                        if (st.dest_mem == DEST_WORK) begin
                            next_st.work = sum[7:0];
                        end else begin
                            next_st.mem_wr = 1'b1;
                            next_st.wdata  = sum[7:0];
                        end
                    end
                    IXO_OP_BSET: begin
                        next_st.mem_wr = 1'b1;
                        next_st.wdata  = st.operand |
                            (8'h01 << st.bit_idx);
                    end
                    IXO_OP_FILL: begin
                        next_st.mem_wr = 1'b1;
                        next_st.wdata  = FILL_VALUE;
                    end
                    default: begin
                        next_st.mem_wr = 1'b0;
                    end
                endcase
                next_st.done  = (st.op != IXO_OP_NONE);
                next_st.phase = IXO_DECODE;
            end
            default: next_st.phase = IXO_DECODE;
        endcase
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            st          <= '0;
            st.phase    <= IXO_DECODE;
            st.op       <= IXO_OP_NONE;
            st.flags    <= FLAGS_RESET;
            st.work     <= WORK_RESET;
        end else if (CE) begin
            st <= next_st;
        end
    end

    assign MEM_ADDR  = st.addr;
    assign MEM_RD    = st.mem_rd;
    assign MEM_WR    = st.mem_wr;
    assign MEM_WDATA = st.wdata;
    assign WORK      = st.work;
    assign FLAGS     = st.flags;
    assign PHASE     = st.phase;
    assign DONE      = st.done;
    assign ILLEGAL   = st.illegal;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RESET);

    a_phase_order_run: assert property (
        CE && st.phase == IXO_DECODE |=> st.phase == IXO_READ)
        else $error("phase did not advance from decode");
    a_phase_wrap: assert property (
        CE && st.phase == IXO_WRITE |=> st.phase == IXO_DECODE)
        else $error("phase did not wrap to decode");
    a_read_issued: assert property (
        CE && st.phase == IXO_READ &&
        (st.op == IXO_OP_ADD || st.op == IXO_OP_BSET) |=> MEM_RD)
        else $error("operand read not issued");
    a_fill_writes_ones: assert property (
        CE && st.phase == IXO_WRITE && st.op == IXO_OP_FILL
        |=> MEM_WR && MEM_WDATA == FILL_VALUE)
        else $error("fill did not write all ones");
    a_fill_keeps_flags: assert property (
        CE && st.phase == IXO_WRITE && st.op != IXO_OP_ADD
        |=> $stable(FLAGS))
        else $error("flags changed on non-add");
    a_bset_sets_bit: assert property (
        CE && st.phase == IXO_WRITE && st.op == IXO_OP_BSET
        |=> MEM_WR && MEM_WDATA[$past(st.bit_idx)])
        else $error("bit set missing");
    a_add_to_work: assert property (
        CE && st.phase == IXO_WRITE && st.op == IXO_OP_ADD &&
        st.dest_mem == DEST_WORK
        |=> !MEM_WR && WORK == $past(st.work) + $past(st.operand))
        else $error("add to work wrong");
    a_add_to_mem: assert property (
        CE && st.phase == IXO_WRITE && st.op == IXO_OP_ADD &&
        st.dest_mem != DEST_WORK |=> MEM_WR && $stable(WORK) &&
        MEM_WDATA == $past(st.work) + $past(st.operand))
        else $error("add to memory wrong");
    // Zero is judged on whichever copy of the sum was updated
    a_add_zero_flag: assert property (
        CE && st.phase == IXO_WRITE && st.op == IXO_OP_ADD
        |=> FLAGS[FL_Z] == (MEM_WR ? MEM_WDATA == 8'h00 : WORK == 8'h00))
        else $error("zero flag wrong");
    a_carry_flag: assert property (
        CE && st.phase == IXO_WRITE && st.op == IXO_OP_ADD
        |=> FLAGS[FL_C] == (9'($past(st.work)) + 9'($past(st.operand))
        > 9'h0ff))
        else $error("carry flag wrong");
    a_addr_formed: assert property (
        CE && st.phase == IXO_DECODE && INSTR_VALID && dif.ofs_ok
        |=> MEM_ADDR == $past(POINTER_TWO_REG) +
        {{(ADDR_W-8){1'b0}}, $past(INSTR[7:0])})
        else $error("effective address wrong");
    a_add_decoded: assert property (
        CE && st.phase == IXO_DECODE && INSTR_VALID &&
        INSTR[15:10] == 6'h09 && !INSTR[8] && dif.ofs_ok
        |=> st.op == IXO_OP_ADD)
        else $error("add not decoded");
    a_refused_no_write: assert property (
        CE && st.phase == IXO_WRITE && st.op == IXO_OP_NONE
        |=> !MEM_WR && !DONE)
        else $error("refused slot wrote or completed");
    a_write_one_cycle: assert property (
        CE && MEM_WR |=> !MEM_WR)
        else $error("write pulse longer than one cycle");
    a_done_pulse: assert property (
        CE && DONE |=> !DONE)
        else $error("done pulse longer than one cycle");
    // Clock enable low must freeze the whole instruction cycle
    a_freeze_holds: assert property (
        !CE |=> $stable(PHASE) && $stable(WORK) && $stable(FLAGS))
        else $error("state moved while frozen");

    // ------------------------------------------------------------
    // Covers
    // ------------------------------------------------------------
    c_add_mem: cover property (st.op == IXO_OP_ADD && MEM_WR);
    c_add_work: cover property (st.op == IXO_OP_ADD && DONE && !MEM_WR);
    c_bset: cover property (st.op == IXO_OP_BSET && MEM_WR);
    c_fill: cover property (st.op == IXO_OP_FILL && MEM_WR);
    c_freeze: cover property (!CE && st.phase == IXO_PROCESS);
endmodule // ixo_exec

// ### ixo_pkg.sv
// Package: encodings, fields, phases and flags of the indexed-offset executor
package ixo_pkg;
    localparam int unsigned DATA_W    = 8;
    localparam int unsigned ADDR_W    = 12;
    localparam int unsigned INSTR_W   = 16;
    // Opcode fields
    localparam logic [3:0]  OPC_ADD_HI   = 4'h2;   // 0010
    localparam logic [3:0]  OPC_FILL_HI  = 4'h6;   // 0110
    localparam logic [3:0]  OPC_FILL_LO  = 4'h8;   // 1000
    localparam logic [3:0]  OPC_BSET_HI  = 4'h8;   // 1000
    localparam logic [3:0]  ADD_LO_MASK  = 4'hd;   // 01d0 with d masked
    localparam logic [3:0]  ADD_LO_VAL   = 4'h4;
    localparam int unsigned DEST_BIT     = 9;
    localparam int unsigned BIDX_LSB     = 9;
    localparam int unsigned BIDX_W       = 3;
    localparam logic [7:0]  OFS_MAX      = 8'h5f;  // 95
    localparam logic [7:0]  FILL_VALUE   = 8'hff;
    localparam logic        DEST_WORK    = 1'b0;
    // Status flag bit positions
    localparam int unsigned FL_C  = 0;
    localparam int unsigned FL_DC = 1;
    localparam int unsigned FL_Z  = 2;
    localparam int unsigned FL_OV = 3;
    localparam int unsigned FL_N  = 4;
    localparam logic [4:0]  FLAGS_RESET = 5'h00;
    localparam logic [7:0]  WORK_RESET  = 8'h00;

    typedef enum logic [1:0] {
        IXO_DECODE  = 2'b00,
        IXO_READ    = 2'b01,
        IXO_PROCESS = 2'b10,
        IXO_WRITE   = 2'b11
    } ixo_phase_e;

    typedef enum logic [1:0] {
        IXO_OP_NONE = 2'b00,
        IXO_OP_ADD  = 2'b01,
        IXO_OP_BSET = 2'b10,
        IXO_OP_FILL = 2'b11
    } ixo_op_e;
endpackage : ixo_pkg

// ### ixo_dec_if.sv
// Interface: decoded instruction passed from decoder to executor
`timescale 1ns/1ns
interface ixo_dec_if;
    import ixo_pkg::*;
    logic [15:0] instr;
    ixo_op_e     op;
    logic        dest_mem;
    logic [2:0]  bit_idx;
    logic [7:0]  offset;
    logic        ofs_ok;
    modport dec (input instr, output op, dest_mem, bit_idx, offset, ofs_ok);
    modport exe (output instr, input op, dest_mem, bit_idx, offset, ofs_ok);
endinterface : ixo_dec_if

// ### ixo_decoder.sv
// Module: combinational decoder of the three indexed-offset instructions
`timescale 1ns/1ns
module ixo_decoder (
    ixo_dec_if.dec d
);
    import ixo_pkg::*;

    always_comb begin
        d.op       = IXO_OP_NONE;
        d.dest_mem = d.instr[DEST_BIT];
        d.bit_idx  = d.instr[BIDX_LSB +: BIDX_W];
        d.offset   = d.instr[7:0];
        d.ofs_ok   = (d.instr[7:0] <= OFS_MAX);
        if (d.instr[15:12] == OPC_ADD_HI &&
            (d.instr[11:8] & ADD_LO_MASK) == ADD_LO_VAL) begin
            d.op = IXO_OP_ADD;
        end else if (d.instr[15:12] == OPC_FILL_HI &&
                     d.instr[11:8] == OPC_FILL_LO) begin
            d.op = IXO_OP_FILL;
        end else if (d.instr[15:12] == OPC_BSET_HI && !d.instr[8]) begin
            d.op = IXO_OP_BSET;
        end
    end
endmodule // ixo_decoder

// ### ixo_mem_model.sv
// Data memory model answering the executor's read and write pulses
`timescale 1ns/1ns
module ixo_mem_model (
    // Clock
    input  wire logic                       CLK,
    // Executor side
    input  wire logic [ixo_pkg::ADDR_W-1:0] MEM_ADDR,
    input  wire logic                       MEM_RD,
    input  wire logic                       MEM_WR,
    input  wire logic [7:0]                 MEM_WDATA,
    output logic      [7:0]                 MEM_RDATA
);
    import ixo_pkg::*;
    logic [7:0] mem [0:4095];
    logic [7:0] junk = 8'h5a;
    // Noise outside a read, so a late sample never sees good data
    always_comb MEM_RDATA = MEM_RD ? mem[MEM_ADDR] : junk;
    always @(posedge CLK) begin
        junk <= ~junk + 8'h01;
        if (MEM_WR) begin
            mem[MEM_ADDR] <= MEM_WDATA;
        end
    end
endmodule // ixo_mem_model

// ### indexed_offset_instr_exec_test.sv
// Self-checking bench of the indexed-offset executor
`timescale 1ns/1ns
module indexed_offset_instr_exec_test;
    import ixo_pkg::*;
    typedef struct {
        logic [15:0] instr; logic [11:0] ptr; logic [7:0] mem;
        logic wr; logic [11:0] addr; logic [7:0] wdata;
        logic [7:0] work; logic [4:0] flags;
    } ixo_row_s;
    logic clk = 1'b0, reset = 1'b1, ce = 1'b1, instr_valid = 1'b0;
    logic [15:0] instr = 16'h0000;
    logic [11:0] ptr = 12'h000, mem_addr;
    logic [7:0]  mem_rdata, mem_wdata, work;
    logic [4:0]  flags;
    logic [1:0]  phase;
    logic        mem_rd, mem_wr, done, illegal;
    int fail_count = 0, cmp_count = 0;
    ixo_row_s rows [7] = '{
        '{16'h2410, 12'h100, 8'h17, 0, 12'h110, 8'h00, 8'h17, 5'h00},
        '{16'h262c, 12'ha00, 8'h20, 1, 12'ha2c, 8'h37, 8'h17, 5'h00},
        '{16'h265f, 12'hfff, 8'he9, 1, 12'h05e, 8'h00, 8'h17, 5'h07},
        '{16'h2401, 12'h010, 8'h70, 0, 12'h011, 8'h00, 8'h87, 5'h18},
        '{16'h8e05, 12'h200, 8'h01, 1, 12'h205, 8'h81, 8'h87, 5'h18},
        '{16'h8000, 12'h300, 8'h80, 1, 12'h300, 8'h81, 8'h87, 5'h18},
        '{16'h6810, 12'h400, 8'h00, 1, 12'h410, 8'hff, 8'h87, 5'h18}};
    ixo_exec u_dut (.CLK(clk), .RESET(reset), .CE(ce), .INSTR(instr),
        .INSTR_VALID(instr_valid), .POINTER_TWO_REG(ptr),
        .MEM_ADDR(mem_addr), .MEM_RD(mem_rd), .MEM_RDATA(mem_rdata),
        .MEM_WR(mem_wr), .MEM_WDATA(mem_wdata), .WORK(work),
        .FLAGS(flags), .PHASE(phase), .DONE(done), .ILLEGAL(illegal));
    ixo_mem_model u_mem (.CLK(clk), .MEM_ADDR(mem_addr), .MEM_RD(mem_rd),
        .MEM_WR(mem_wr), .MEM_WDATA(mem_wdata), .MEM_RDATA(mem_rdata));
    initial begin
        forever #25 clk = ~clk;
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // --------------------------------------------------------------
    // One instruction: issue, optional freeze, four working edges
    // --------------------------------------------------------------
    task automatic run(input ixo_row_s r, input int stall);
        int n;
        u_mem.mem[r.addr] = r.mem;
        n = 0;
        instr <= r.instr;
        ptr <= r.ptr;
        instr_valid <= 1'b1;
        // Request stands until a decode edge takes it
        do begin
            @(posedge clk);
            @(negedge clk);
            n++;
        end while (phase !== IXO_READ && n < 8);
        if (n >= 8) begin
            fail_count++;
            final_report();
        end
        @(posedge clk);
        instr_valid <= 1'b0;
        if (stall > 0) begin
            ce <= 1'b0;
            repeat (stall) @(posedge clk);
            @(negedge clk);
            chk(phase, IXO_PROCESS);
            chk(mem_rd, 1'b1);
            @(posedge clk);
            ce <= 1'b1;
        end
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk(mem_wr, r.wr);
        if (r.wr) chk(mem_addr, r.addr);
        if (r.wr) chk(mem_wdata, r.wdata);
        chk(work, r.work);
        chk(flags, r.flags);
        chk(phase, IXO_DECODE);
    endtask
    initial begin
        #2000000 fail_count++;
        final_report();
    end
    initial begin
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        #1 chk({work, 3'h0, flags}, 16'h0000);
        chk({phase, done, mem_wr, mem_rd, illegal}, 6'h00);
        foreach (rows[i]) begin
            @(posedge clk);
            run(rows[i], 0);
            chk(done, 1'b1);
            $display("row %0d done", i);
        end
        @(posedge clk);
        run('{16'h2460, 12'h000, 8'h55, 0, 12'h060, 8'h0, 8'h87, 5'h18}, 0);
        chk(illegal, 1'b1);
        chk(done, 1'b0);
        @(posedge clk);
        run('{16'hffff, 12'h000, 8'h55, 0, 12'h0ff, 8'h0, 8'h87, 5'h18}, 0);
        chk({illegal, done}, 2'h0);
        @(posedge clk);
        run('{16'h2601, 12'h000, 8'h01, 1, 12'h001, 8'h88, 8'h87, 5'h10}, 3);
        $display("refusal and freeze tests done");
        @(posedge clk);
        instr <= 16'h2601;
        instr_valid <= 1'b1;
        // Taken at the fourth edge, reset lands while it is in flight
        repeat (5) @(posedge clk);
        instr_valid <= 1'b0;
        reset <= 1'b1;
        @(posedge clk);
        reset <= 1'b0;
        #1 chk({work, 3'h0, flags}, 16'h0000);
        chk({phase, mem_wr, mem_rd, done}, 5'h00);
        repeat (4) @(posedge clk);
        @(negedge clk);
        chk({mem_wr, done}, 2'h0);
        $display("reset test done");
        final_report();
    end
endmodule // indexed_offset_instr_exec_test
